// File: src/tdcm_core.sv
// hit capture, first-level store, trigger matching and read-out FIFO
// assumes hit, trigger and reset inputs synchronous to clk; Avalon-MM slave
//
// The Avalon-MM slave port and the address map are this design's own decisions.
module tdcm_core #(
  parameter int NCH = tdcm_pkg::NCH
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  input  wire logic [NCH-1:0]        hit_lead,
  input  wire logic [NCH-1:0]        hit_trail,
  input  wire logic [NCH-1:0]        hit_half,
  input  wire logic [NCH-1:0][15:0]  hit_taps,
  input  wire logic                  trigger,
  input  wire logic                  bunch_rst,
  input  wire logic                  event_rst
);
  localparam int CAW = $clog2(tdcm_pkg::CH_DEPTH);
  localparam int LAW = $clog2(tdcm_pkg::L1_DEPTH);
  localparam int TAW = $clog2(tdcm_pkg::TQ_DEPTH);
  localparam int RAW = $clog2(tdcm_pkg::RO_DEPTH);
  if (NCH < 1 || NCH > 24) begin : g_bad
    $error("NCH must lie in 1..24");
  end

  function automatic logic [11:0] tdiff(input logic [11:0] a, input logic [11:0] b,
                                        input logic [11:0] r);
    tdiff = (a >= b) ? 12'(a - b) : 12'(a - b + r + 12'h001);
  endfunction : tdiff

  function automatic logic [3:0] venc(input logic [15:0] t);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + 5'(t[i]);
    end
    venc = (n > 5'h0f) ? 4'hf : n[3:0];
  endfunction : venc

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  logic [11:0] mode_q;
  logic [12:0] cofs_q;
  logic [11:0] roll_q, tofs_q, rofs_q, mwin_q, kwin_q, swin_q;
  logic        grst_q;
  logic [11:0] evt_ctr_q;
  logic [7:0]  lost_cnt_q;
  logic [LAW:0] l1_cnt_q;
  logic [RAW:0] ro_cnt_q;
  logic [31:0]  ro_mem_q [tdcm_pkg::RO_DEPTH];
  logic [RAW-1:0] ro_rp_q, ro_wp_q;
  // pop only a word that was shown, not one pushed during the access
  logic pop_ok_q;
  wire wr_done  = write & ~waitrequest;
  wire ro_pop   = read & ~waitrequest & pop_ok_q;
  tdcm_pkg::tdcm_edge_t em;
  assign em = tdcm_pkg::tdcm_edge_t'(mode_q[tdcm_pkg::M_EDGE +: 2]);
  wire [3:0] tdc_id = mode_q[tdcm_pkg::M_ID +: 4];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      pop_ok_q    <= 1'b0;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      pop_ok_q    <= read & waitrequest & (address == tdcm_pkg::A_DATA) & (ro_cnt_q != '0);
      if (read && waitrequest) begin
        case (address)
          tdcm_pkg::A_MODE: readdata <= {20'h00000, mode_q};
          tdcm_pkg::A_COFS: readdata <= {19'h00000, cofs_q};
          tdcm_pkg::A_ROLL: readdata <= {20'h00000, roll_q};
          tdcm_pkg::A_TOFS: readdata <= {20'h00000, tofs_q};
          tdcm_pkg::A_ROFS: readdata <= {20'h00000, rofs_q};
          tdcm_pkg::A_MWIN: readdata <= {20'h00000, mwin_q};
          tdcm_pkg::A_KWIN: readdata <= {20'h00000, kwin_q};
          tdcm_pkg::A_SWIN: readdata <= {20'h00000, swin_q};
          tdcm_pkg::A_STAT: readdata <= {lost_cnt_q, 1'b0, 7'(ro_cnt_q), 7'h00, 9'(l1_cnt_q)};
          tdcm_pkg::A_DATA: readdata <= (ro_cnt_q != '0) ? ro_mem_q[ro_rp_q] : 32'h0000_0000;
          tdcm_pkg::A_EVT:  readdata <= {20'h00000, evt_ctr_q};
          default:          readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= tdcm_pkg::MODE_RST;
      cofs_q <= 13'h0000;
      roll_q <= tdcm_pkg::ROLL_RST;
      tofs_q <= tdcm_pkg::OFS_RST;
      rofs_q <= tdcm_pkg::OFS_RST;
      mwin_q <= tdcm_pkg::MWIN_RST;
      kwin_q <= tdcm_pkg::KWIN_RST;
      swin_q <= tdcm_pkg::SWIN_RST;
      grst_q <= 1'b0;
    end else begin
      grst_q <= wr_done & (address == tdcm_pkg::A_CMD) & writedata[tdcm_pkg::CMD_GRST];
      if (wr_done) begin
        case (address)
          tdcm_pkg::A_MODE: mode_q <= writedata[11:0];
          tdcm_pkg::A_COFS: cofs_q <= {writedata[12:1], 1'b0};
          tdcm_pkg::A_ROLL: roll_q <= writedata[11:0];
          tdcm_pkg::A_TOFS: tofs_q <= writedata[11:0];
          tdcm_pkg::A_ROFS: rofs_q <= writedata[11:0];
          tdcm_pkg::A_MWIN: mwin_q <= writedata[11:0];
          tdcm_pkg::A_KWIN: kwin_q <= writedata[11:0];
          tdcm_pkg::A_SWIN: swin_q <= writedata[11:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bunch counter: upper twelve bits of the coarse count, LSB is the half phase
  logic [11:0] bunch_q, bunch_prev_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bunch_q      <= 12'h000;
      bunch_prev_q <= 12'h000;
    end else begin
      bunch_prev_q <= bunch_q;
      if (grst_q || bunch_rst) begin
        bunch_q <= cofs_q[12:1];
      end else begin
        bunch_q <= (bunch_q == roll_q) ? 12'h000 : 12'(bunch_q + 12'h001);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel buffers
  tdcm_pkg::tdcm_chent_t head [NCH];
  tdcm_pkg::tdcm_chent_t nxt  [NCH];
  logic [NCH-1:0]        req;
  logic [1:0]            popn [NCH];
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    tdcm_pkg::tdcm_chent_t mem_q [tdcm_pkg::CH_DEPTH];
    logic [CAW-1:0] wp_q, rp_q;
    logic [CAW:0]   cnt_q;
    logic lost_q, s1_q, s2_q;
    wire take_l = hit_lead[c] & (em != tdcm_pkg::EM_TRAIL);
    wire take_t = hit_trail[c] & (em != tdcm_pkg::EM_LEAD) & ~take_l;
    wire [3:0] vern = venc(hit_taps[c]);
    // late vernier: counter may be mid-change, use the earlier sample
    wire [12:0] coarse = vern[3] ? {bunch_prev_q, hit_half[c]} : {bunch_q, hit_half[c]};
    wire full = (cnt_q == (CAW + 1)'(tdcm_pkg::CH_DEPTH));
    wire put  = (take_l | take_t) & ~full;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        wp_q   <= '0;
        rp_q   <= '0;
        cnt_q  <= '0;
        lost_q <= 1'b0;
      end else if (grst_q) begin
        wp_q   <= '0;
        rp_q   <= '0;
        cnt_q  <= '0;
        lost_q <= 1'b0;
      end else begin
        if (put) begin
          mem_q[wp_q] <= '{trail: take_t, lost: lost_q, coarse: coarse, vern: vern};
          wp_q        <= wp_q + 1'b1;
        end
        rp_q  <= rp_q + CAW'(popn[c]);
        cnt_q <= cnt_q + (CAW + 1)'(put) - (CAW + 1)'(popn[c]);
        if ((take_l | take_t) && full) begin
          lost_q <= 1'b1;
        end else if (put) begin
          lost_q <= 1'b0;
        end
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= (cnt_q != '0);
        s2_q <= s1_q;
      end
    end
    assign head[c] = mem_q[rp_q];
    assign nxt[c]  = mem_q[rp_q + 1'b1];
    // a paired lead waits for its trailing edge
    assign req[c]  = s2_q & (cnt_q != '0) &
                     ~((em == tdcm_pkg::EM_PAIR) & ~mem_q[rp_q].trail & (cnt_q < 2));
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and encoder
  logic [NCH-1:0] active_q;
  logic [4:0]     sel;
  logic           enc_v, orphan, paired;
  tdcm_pkg::tdcm_l1ent_t enc_e;
  logic [16:0]    dt;
  always_comb begin
    sel = 5'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (active_q[i]) sel = 5'(i);
    end
    enc_v  = (active_q != '0) & req[sel];
    paired = (em == tdcm_pkg::EM_PAIR) & ~head[sel].trail;
    orphan = (em == tdcm_pkg::EM_PAIR) & head[sel].trail;
    dt = {nxt[sel].coarse, nxt[sel].vern} - {head[sel].coarse, head[sel].vern};
    if ({nxt[sel].coarse, nxt[sel].vern} < {head[sel].coarse, head[sel].vern}) begin
      dt = dt + {roll_q + 12'h001, 5'h00};
    end
    dt = dt >> mode_q[tdcm_pkg::M_RES +: 3];
    enc_e        = '0;
    enc_e.coarse = head[sel].coarse[12:1];
    enc_e.fine   = {head[sel].coarse[0], head[sel].vern};
    enc_e.ch     = sel;
    enc_e.trail  = head[sel].trail;
    enc_e.paired = paired;
    enc_e.lost   = head[sel].lost | (paired & nxt[sel].lost);
    enc_e.width  = paired ? ((dt > 17'h000ff) ? 8'hff : dt[7:0]) : 8'h00;
    for (int i = 0; i < NCH; i++) begin
      popn[i] = (enc_v && sel == 5'(i)) ? (paired ? 2'd2 : 2'd1) : 2'd0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_q <= '0;
    end else if (grst_q) begin
      active_q <= '0;
    end else if (active_q == '0) begin
      active_q <= req;
    end else begin
      active_q[sel] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first-level hit store
  tdcm_pkg::tdcm_l1ent_t first_level_hit_store [tdcm_pkg::L1_DEPTH];
  logic [LAW-1:0] l1_wp_q, l1_tail_q;
  logic l1_drop_q, l1_free, ev_l1ovf;
  wire l1_wr   = enc_v & ~orphan;
  wire l1_full = (l1_cnt_q == (LAW + 1)'(tdcm_pkg::L1_DEPTH)) & ~l1_free;
  wire l1_put  = l1_wr & ~l1_full;
  assign ev_l1ovf = l1_wr & l1_full;
  tdcm_pkg::tdcm_l1ent_t l1_new;
  always_comb begin
    l1_new       = enc_e;
    l1_new.full  = (l1_cnt_q == (LAW + 1)'(tdcm_pkg::L1_DEPTH - 1)) & ~l1_free;
    l1_new.recov = l1_drop_q;
    l1_new.par   = ^l1_new;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      l1_wp_q   <= '0;
      l1_tail_q <= '0;
      l1_cnt_q  <= '0;
      l1_drop_q <= 1'b0;
    end else if (grst_q) begin
      l1_wp_q   <= '0;
      l1_tail_q <= '0;
      l1_cnt_q  <= '0;
      l1_drop_q <= 1'b0;
    end else begin
      if (l1_put) begin
        first_level_hit_store[l1_wp_q] <= l1_new;
        l1_wp_q <= l1_wp_q + 1'b1;
      end
      if (l1_free) l1_tail_q <= l1_tail_q + 1'b1;
      l1_cnt_q <= l1_cnt_q + (LAW + 1)'(l1_put) - (LAW + 1)'(l1_free);
      if (ev_l1ovf) begin
        l1_drop_q <= 1'b1;
      end else if (l1_put) begin
        l1_drop_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger queue
  tdcm_pkg::tdcm_trig_t tq_mem_q [tdcm_pkg::TQ_DEPTH];
  logic [TAW-1:0] tq_rp_q, tq_wp_q;
  logic [TAW:0]   tq_cnt_q;
  logic [11:0]    lost_evt_q;
  logic           tq_pop, lost_take;
  wire tq_full  = (tq_cnt_q == (TAW + 1)'(tdcm_pkg::TQ_DEPTH));
  wire tq_push  = trigger & ~tq_full;
  wire ev_tqovf = trigger & tq_full;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tq_rp_q    <= '0;
      tq_wp_q    <= '0;
      tq_cnt_q   <= '0;
      evt_ctr_q  <= 12'h000;
      lost_cnt_q <= 8'h00;
      lost_evt_q <= 12'h000;
    end else if (grst_q) begin
      tq_rp_q    <= '0;
      tq_wp_q    <= '0;
      tq_cnt_q   <= '0;
      evt_ctr_q  <= 12'h000;
      lost_cnt_q <= 8'h00;
      lost_evt_q <= 12'h000;
    end else begin
      if (tq_push) begin
        tq_mem_q[tq_wp_q] <= '{tag: tdiff(bunch_q, tofs_q, roll_q), evt: evt_ctr_q};
        tq_wp_q <= tq_wp_q + 1'b1;
      end
      if (tq_pop) tq_rp_q <= tq_rp_q + 1'b1;
      tq_cnt_q <= tq_cnt_q + (TAW + 1)'(tq_push) - (TAW + 1)'(tq_pop);
      if (event_rst) begin
        evt_ctr_q <= 12'h000;
      end else if (trigger) begin
        evt_ctr_q <= 12'(evt_ctr_q + 12'h001);
      end
      // a loss in the same cycle as a take is kept
      lost_cnt_q <= 8'(lost_cnt_q + 8'(ev_tqovf) - 8'(lost_take));
      if (ev_tqovf && (lost_cnt_q == 8'h00 || (lost_cnt_q == 8'h01 && lost_take))) begin
        lost_evt_q <= evt_ctr_q;
      end else if (lost_take) begin
        lost_evt_q <= 12'(lost_evt_q + 12'h001);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger matching
  typedef enum logic [2:0] {M_IDLE, M_HDR, M_SCAN, M_MASK, M_ERR, M_TRL} tdcm_mst_t;
  tdcm_mst_t      st_q;
  logic [11:0]    tag_q, evt_q, wc_q;
  logic           lostev_q;
  logic [LAW-1:0] idx_q;
  logic [LAW:0]   left_q;
  logic [NCH-1:0] mask_q;
  logic [3:0]     err_q, err_ev;
  logic           ro_push, ro_full;
  logic [31:0]    ro_word;
  tdcm_pkg::tdcm_l1ent_t ent, tent;
  logic [11:0]    d, b, rj;
  logic           in_match, in_mask, old, par_err;
  assign ro_full = (ro_cnt_q == (RAW + 1)'(tdcm_pkg::RO_DEPTH));
  always_comb begin
    ent      = first_level_hit_store[idx_q];
    tent     = first_level_hit_store[l1_tail_q];
    d        = tdiff(ent.coarse, tag_q, roll_q);
    b        = tdiff(tag_q, ent.coarse, roll_q);
    rj       = tdiff(tdiff(bunch_q, rofs_q, roll_q), tent.coarse, roll_q);
    in_match = (d <= mwin_q);
    in_mask  = mode_q[tdcm_pkg::M_MASK] & (b != 12'h000) & (b <= kwin_q);
    old      = (b > swin_q) & (d > swin_q) & (b < d);
    par_err  = (st_q == M_SCAN) & (left_q != '0) & (^ent);
    err_ev   = '0;
    err_ev[tdcm_pkg::E_L1OVF] = ev_l1ovf | ((st_q == M_SCAN) & in_match & (left_q != '0) &
                                (ent.full | ent.recov));
    err_ev[tdcm_pkg::E_TQOVF] = ev_tqovf;
    err_ev[tdcm_pkg::E_PAR]   = par_err;
    tq_pop    = (st_q == M_IDLE) & (tq_cnt_q != '0);
    lost_take = (st_q == M_IDLE) & (tq_cnt_q == '0) & (lost_cnt_q != 8'h00);
    l1_free   = 1'b0;
    if (st_q == M_SCAN && left_q != '0 && idx_q == l1_tail_q && old) begin
      l1_free = 1'b1;
    end
    if (st_q == M_IDLE && !tq_pop && !lost_take && mode_q[tdcm_pkg::M_REJ] &&
        l1_cnt_q != '0 && rj != 12'h000 && !rj[11]) begin
      l1_free = 1'b1;
    end
    ro_push = 1'b0;
    ro_word = 32'h0000_0000;
    case (st_q)
      M_HDR: begin
        ro_push = ~ro_full;
        ro_word = {tdcm_pkg::TY_HDR, tdc_id, evt_q, tag_q};
      end
      M_SCAN: begin
        ro_push = ~ro_full & (left_q != '0) & in_match & ~par_err;
        ro_word = ent.paired ?
                  {tdcm_pkg::TY_CMB, tdc_id, ent.ch, ent.width, ent.coarse[5:0], ent.fine} :
                  {tdcm_pkg::TY_SGL, tdc_id, ent.ch, ent.trail, ent.lost, ent.coarse, ent.fine};
      end
      M_MASK: begin
        ro_push = ~ro_full & (mask_q != '0);
        ro_word = {tdcm_pkg::TY_MASK, tdc_id, 24'(mask_q)};
      end
      M_ERR: begin
        ro_push = ~ro_full & ((err_q | err_ev) != 4'h0);
        ro_word = {tdcm_pkg::TY_ERR, tdc_id, 20'h00000, err_q | err_ev};
      end
      M_TRL: begin
        ro_push = ~ro_full;
        ro_word = {tdcm_pkg::TY_TRL, tdc_id, evt_q, 12'(wc_q + 12'h001)};
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q     <= M_IDLE;
      tag_q    <= 12'h000;
      evt_q    <= 12'h000;
      wc_q     <= 12'h000;
      lostev_q <= 1'b0;
      idx_q    <= '0;
      left_q   <= '0;
      mask_q   <= '0;
      err_q    <= 4'h0;
    end else if (grst_q) begin
      st_q <= M_IDLE;
    end else begin
      if (ro_push) wc_q <= 12'(wc_q + 12'h001);
      err_q <= err_q | err_ev;
      case (st_q)
        M_IDLE: begin
          wc_q   <= 12'h000;
          mask_q <= '0;
          err_q  <= err_ev;
          if (tq_pop || lost_take) begin
            tag_q    <= tq_pop ? tq_mem_q[tq_rp_q].tag : bunch_q;
            evt_q    <= tq_pop ? tq_mem_q[tq_rp_q].evt : lost_evt_q;
            lostev_q <= lost_take;
            st_q     <= M_HDR;
          end
        end
        M_HDR: begin
          idx_q  <= l1_tail_q;
          left_q <= l1_cnt_q;
          if (!ro_full) st_q <= lostev_q ? M_ERR : M_SCAN;
          if (lostev_q) err_q[tdcm_pkg::E_LOST] <= 1'b1;
        end
        M_SCAN: begin
          if (left_q == '0) begin
            st_q <= M_MASK;
          end else if (!(in_match && !par_err && ro_full)) begin
            idx_q  <= idx_q + 1'b1;
            left_q <= left_q - 1'b1;
            if (in_mask) mask_q[ent.ch] <= 1'b1;
          end
        end
        M_MASK: if (!ro_full) st_q <= M_ERR;
        M_ERR:  if (!ro_full) st_q <= M_TRL;
        M_TRL:  if (!ro_full) st_q <= M_IDLE;
        default: st_q <= M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-out FIFO
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ro_rp_q  <= '0;
      ro_wp_q  <= '0;
      ro_cnt_q <= '0;
    end else if (grst_q) begin
      ro_rp_q  <= '0;
      ro_wp_q  <= '0;
      ro_cnt_q <= '0;
    end else begin
      if (ro_push) begin
        ro_mem_q[ro_wp_q] <= ro_word;
        ro_wp_q <= ro_wp_q + 1'b1;
      end
      if (ro_pop) ro_rp_q <= ro_rp_q + 1'b1;
      ro_cnt_q <= ro_cnt_q + (RAW + 1)'(ro_push) - (RAW + 1)'(ro_pop);
    end
  end
endmodule : tdcm_core

// File: src/tdcm_pkg.sv
// constants, types and map of the hit/trigger matching core
// assumes one 40 MHz clock and an Avalon-MM register master
// Function
// - 13-bit coarse counter, even offset at reset
// - two counter samples one cycle apart, fine time picks one
// - coarse counter at twice bunch rate
// - bunch reset input, programmable roll-over wrap
// - sixteen taps encoded to vernier value
// - four measurements per channel buffer
// - leading, trailing, both or paired edges
// - full channel drops hit, flags next one
// - channel status through two-stage synchronisers
// - paired pop stores lead plus 8-bit width
// - coarse upper twelve, fine LSB plus vernier
// - queue refills when empty, channel 0 first
// - 256-word circular store, random reads
// - full flag on last, recover on next
// - match from tag to tag plus window
// - search window wider than match window
// - reject old hits while trigger queue empty
// - optional mask flags, one word per event
// - errors during matching add error word
// - header with event, bunch; trailer with count
// - trigger pushes offset tag and event number
// - count lost triggers, emit lost events later
// - event number twelve bits wide
// - read-out FIFO sixty-four words deep
package tdcm_pkg;
  localparam int NCH      = 24;
  localparam int CH_DEPTH = 4;
  localparam int L1_DEPTH = 256;
  localparam int TQ_DEPTH = 8;
  localparam int RO_DEPTH = 64;
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_COFS = 8'h04;
  localparam logic [7:0] A_ROLL = 8'h08;
  localparam logic [7:0] A_TOFS = 8'h0c;
  localparam logic [7:0] A_ROFS = 8'h10;
  localparam logic [7:0] A_MWIN = 8'h14;
  localparam logic [7:0] A_KWIN = 8'h18;
  localparam logic [7:0] A_SWIN = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_DATA = 8'h24;
  localparam logic [7:0] A_CMD  = 8'h28;
  localparam logic [7:0] A_EVT  = 8'h2c;
  localparam int M_EDGE = 0;
  localparam int M_MASK = 2;
  localparam int M_REJ  = 3;
  localparam int M_RES  = 4;
  localparam int M_ID   = 8;
  localparam int CMD_GRST = 0;
  localparam logic [11:0] MODE_RST = 12'h002;
  localparam logic [11:0] ROLL_RST = 12'hfff;
  localparam logic [11:0] MWIN_RST = 12'h010;
  localparam logic [11:0] KWIN_RST = 12'h008;
  localparam logic [11:0] SWIN_RST = 12'h020;
  localparam logic [11:0] OFS_RST  = 12'h000;
  localparam logic [3:0] TY_HDR  = 4'ha;
  localparam logic [3:0] TY_TRL  = 4'hc;
  localparam logic [3:0] TY_MASK = 4'h2;
  localparam logic [3:0] TY_SGL  = 4'h3;
  localparam logic [3:0] TY_CMB  = 4'h4;
  localparam logic [3:0] TY_ERR  = 4'h6;
  localparam int E_L1OVF = 0;
  localparam int E_TQOVF = 1;
  localparam int E_PAR   = 2;
  localparam int E_LOST  = 3;
  typedef enum logic [1:0] {EM_LEAD, EM_TRAIL, EM_BOTH, EM_PAIR} tdcm_edge_t;
  typedef struct packed {
    logic        trail;
    logic        lost;
    logic [12:0] coarse;
    logic [3:0]  vern;
  } tdcm_chent_t;
  typedef struct packed {
    logic        par;
    logic        full;
    logic        recov;
    logic        lost;
    logic        paired;
    logic        trail;
    logic [4:0]  ch;
    logic [7:0]  width;
    logic [11:0] coarse;
    logic [4:0]  fine;
  } tdcm_l1ent_t;
  typedef struct packed {
    logic [11:0] tag;
    logic [11:0] evt;
  } tdcm_trig_t;
endpackage : tdcm_pkg

// File: tb/tdcm_front.sv
// front end model: discriminator edges and trigger pulses
// assumes bench requests are sampled on the rising edge
module tdcm_front (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [4:0]                    ch,
  input  wire logic                          half,
  input  wire logic [15:0]                   taps,
  input  wire logic                          go_hit,
  input  wire logic                          go_trig,
  output logic      [tdcm_pkg::NCH-1:0]      hit_lead,
  output logic      [tdcm_pkg::NCH-1:0]      hit_half,
  output logic      [tdcm_pkg::NCH-1:0][15:0] hit_taps,
  output logic                               trigger
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_lead <= '0;
      hit_half <= '0;
      hit_taps <= '0;
      trigger  <= 1'b0;
    end else begin
      hit_lead <= go_hit ? 24'(1) << ch : '0;
      // idle sample lines toggle so stale values never look valid
      hit_half <= ~hit_half;
      hit_taps <= ~hit_taps;
      if (go_hit) begin
        hit_half[ch] <= half;
        hit_taps[ch] <= taps;
      end
      trigger <= go_trig;
    end
  end
endmodule : tdcm_front

// File: tb/tdcm_monitor.sv
// checker on the core's bus ports
// assumes it is bound into tdcm_core
module tdcm_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest ##1 waitrequest; endsequence
  sequence s_rd(a); read && waitrequest && address == a; endsequence
  property p_hs; s_req |=> s_ans; endproperty
  a_hs: assert property (p_hs) else $error("no one-cycle answer");
  property p_cause; !waitrequest |-> $past(read || write) && $past(waitrequest); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_idle; !(read || write) |=> waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer while idle");
  property p_hold; !(read && waitrequest) |=> $stable(readdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; read && waitrequest && address > 8'h2c |=> readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_cofs; s_rd(tdcm_pkg::A_COFS) |=> !readdata[0]; endproperty
  a_cofs: assert property (p_cofs) else $error("offset lsb set");
  property p_stat; s_rd(tdcm_pkg::A_STAT) |=> readdata[22:16] <= 7'd64 && readdata[8:0] <= 9'd256;
  endproperty
  a_stat: assert property (p_stat) else $error("fill count too high");
  property p_evt; s_rd(tdcm_pkg::A_EVT) |=> readdata[31:12] == 20'h0; endproperty
  a_evt: assert property (p_evt) else $error("event number too wide");
endmodule : tdcm_monitor

bind tdcm_core tdcm_monitor u_tdcm_monitor (.clk(clk), .rst(rst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest));

// File: tb/testbench.sv
// bench: registers, hit matching, trigger burst, global reset
// assumes tdcm_core, tdcm_front and the monitor bind
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [4:0]  ch = '0;
  logic        half = 1'b0;
  logic [15:0] taps = '0;
  logic        go_hit = 1'b0;
  logic        go_trig = 1'b0;
  logic [23:0] hit_lead;
  logic [23:0] hit_half;
  logic [23:0][15:0] hit_taps;
  logic        trigger;
  logic [31:0] q;
  logic [31:0] wq[$];
  int          n_errors = 0;
  int          tests_run = 0;
  int          seed = 32'h121a097d;
  int          ev = 0;
  int          nw;
  logic [7:0]  ra [5] = '{tdcm_pkg::A_MODE, tdcm_pkg::A_ROLL, tdcm_pkg::A_MWIN,
                          tdcm_pkg::A_KWIN, tdcm_pkg::A_SWIN};
  logic [11:0] rv [5] = '{tdcm_pkg::MODE_RST, tdcm_pkg::ROLL_RST, tdcm_pkg::MWIN_RST,
                          tdcm_pkg::KWIN_RST, tdcm_pkg::SWIN_RST};
  always #12.5 clk = ~clk;
  ////////////////////////////////
  tdcm_core u_tdcm_core (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .hit_lead(hit_lead), .hit_trail('0), .hit_half(hit_half), .hit_taps(hit_taps),
    .trigger(trigger), .bunch_rst(1'b0), .event_rst(1'b0));
  tdcm_front u_tdcm_front (.clk(clk), .rst(rst), .ch(ch), .half(half), .taps(taps),
    .go_hit(go_hit), .go_trig(go_trig), .hit_lead(hit_lead), .hit_half(hit_half),
    .hit_taps(hit_taps), .trigger(trigger));
  ////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= ~w;
    write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_errors++;
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd_evt(output int nw);
    int n;
    n = 0;
    q = '0;
    while (q[31:28] !== tdcm_pkg::TY_HDR && n < 400) begin
      bus(1'b0, tdcm_pkg::A_DATA, '0, q);
      n++;
    end
    chk("header type", tdcm_pkg::TY_HDR, q[31:28]);
    chk("header event", ev, q[23:12]);
    wq = {q};
    while (q[31:28] !== tdcm_pkg::TY_TRL && n < 800) begin
      bus(1'b0, tdcm_pkg::A_DATA, '0, q);
      wq.push_back(q);
      n++;
    end
    nw = wq.size();
    chk("trailer type", tdcm_pkg::TY_TRL, q[31:28]);
    chk("trailer event", ev, q[23:12]);
    chk("word count", nw, q[11:0]);
    ev = (ev + 1) % 4096;
  endtask : rd_evt
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  ////////////////////////////////
  initial begin
    #2000000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], '0, q);
      chk("reset value", rv[i], q);
    end
    bus(1'b1, tdcm_pkg::A_COFS, 32'h555, q);
    bus(1'b0, tdcm_pkg::A_COFS, '0, q);
    chk("offset", 32'h554, q);
    bus(1'b1, 8'h40, 32'h1, q);
    bus(1'b0, 8'h40, '0, q);
    chk("unmapped", '0, q);
    bus(1'b1, tdcm_pkg::A_TOFS, 32'hc, q);
    ch <= 5'(unsigned'($random(seed)) % 24);
    taps <= 16'($random(seed));
    half <= 1'($random(seed));
    go_hit <= 1'b1;
    @(posedge clk);
    go_hit <= 1'b0;
    repeat (10) @(posedge clk);
    go_trig <= 1'b1;
    @(posedge clk);
    go_trig <= 1'b0;
    rd_evt(nw);
    chk("words", 3, nw);
    chk("hit type", tdcm_pkg::TY_SGL, wq[1][31:28]);
    chk("channel", ch, wq[1][23:19]);
    chk("fine", {half, $countones(taps) > 15 ? 4'hf : 4'($countones(taps))},
        wq[1][4:0]);
    // back-to-back triggers overrun the trigger queue; the last ones come back as lost events
    go_trig <= 1'b1;
    repeat (12) @(posedge clk);
    go_trig <= 1'b0;
    repeat (12) rd_evt(nw);
    chk("lost words", 3, nw);
    chk("lost flag", 32'h6000_0008, wq[1]);
    bus(1'b0, tdcm_pkg::A_EVT, '0, q);
    chk("event count", ev, q);
    bus(1'b1, tdcm_pkg::A_CMD, 32'h1, q);
    repeat (2) @(posedge clk);
    bus(1'b0, tdcm_pkg::A_EVT, '0, q);
    chk("event cleared", '0, q);
    bus(1'b0, tdcm_pkg::A_STAT, '0, q);
    chk("status cleared", '0, q);
    final_report();
  end
endmodule : testbench
